// ### hw/buck_rail_defs.vh
// register offsets, field positions, reset values and mode codes of the buck rail control bank
// assumes inclusion by bare name from design files under hw/
`ifndef BUCK_RAIL_DEFS_VH
`define BUCK_RAIL_DEFS_VH
// ****************************************
// register offsets
// ****************************************
`define MEMORY_RAIL_CONTROL_ADDR 8'h37
`define RAIL_2V1_CONTROL_ADDR 8'h38
`define RAIL_1V5_CONTROL_ADDR 8'h39
`define CURRENT_MEMORY_RAIL_ADDR 8'h3a
`define CURRENT_RAIL_2V1_ADDR 8'h3b
`define CURRENT_RAIL_1V5_ADDR 8'h3c
`define FAULT_STATUS_ADDR 8'h3d
// ****************************************
// reset values
// ****************************************
`define MEMORY_RAIL_CONTROL_RESET 8'h04
`define RAIL_2V1_CONTROL_RESET 8'h07
`define RAIL_1V5_CONTROL_RESET 8'h07
// ****************************************
// field positions and codes
// ****************************************
`define RUN_MODE_MSB 2
`define RUN_MODE_LSB 0
`define EXIT_MODE_MSB 5
`define EXIT_MODE_LSB 3
`define VSEL_MSB 7
`define VSEL_LSB 6
`define MODE_OFF 3'h4
`define MODE_PFM 3'h5
`define MODE_APS 3'h6
`define MODE_PWM 3'h7
`define VSEL_1V5 2'h0
`define VSEL_1V6 2'h1
`endif

// ### hw/buck_rail_mode_control.v
// control and status register bank for three buck rails: memory, 2.1 V and 1.5 V
// assumes a byte-wide register port decoded by a spi slave on clk_in; pins are asynchronous
`timescale 1ns/1ps
`include "buck_rail_defs.vh"
module buck_rail_mode_control #(
  parameter ADC_WIDTH = 8
) (
  input wire clk_in,
  input wire resetn_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  output reg [7:0] reg_rdata_out,
  input wire standby_exit_pin_in,
  input wire [2:0] overcurrent_in,
  input wire gps_comm_rail_1v3_in,
  input wire [ADC_WIDTH-1:0] adc_result_in,
  input wire [1:0] adc_channel_in,
  input wire adc_valid_in,
  output reg [2:0] memory_rail_mode_out,
  output reg [2:0] rail_2v1_mode_out,
  output reg [2:0] rail_1v5_mode_out,
  output reg rail_1v5_voltage_select_out,
  output reg [2:0] discharge_out,
  output reg memory_rail_fault_out,
  output reg rail_2v1_fault_out,
  output reg rail_1v5_fault_out,
  output reg regulator_fault_irq_out
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  reg exit_prev_r;
  wire exit_rise;
  wire gps_1v3;
  wire [2:0] ovc;

  // two flops on every asynchronous pin
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      exit_prev_r <= 1'b0;
    end else begin
      sync1_r <= {gps_comm_rail_1v3_in, standby_exit_pin_in, overcurrent_in};
      sync2_r <= sync1_r;
      exit_prev_r <= sync2_r[3];
    end
  end

  assign ovc = sync2_r[2:0];
  assign gps_1v3 = sync2_r[4];
  assign exit_rise = sync2_r[3] & ~exit_prev_r;

  // ****************************************
  // control registers
  // ****************************************
  reg [5:0] mem_ctl_r;
  reg [5:0] r21_ctl_r;
  reg [7:0] r15_ctl_r;
  reg [5:0] mem_ctl_nxt;
  reg [5:0] r21_ctl_nxt;
  reg [7:0] r15_ctl_nxt;

  // reset values as bytes; bits 7:6 of the first two registers are not stored
  localparam [7:0] MEM_CTL_RESET = `MEMORY_RAIL_CONTROL_RESET;
  localparam [7:0] R21_CTL_RESET = `RAIL_2V1_CONTROL_RESET;

  // exit copy: codes 0..3 (top bit clear) mean no copy
  function [2:0] exit_copy;
    input [2:0] run;
    input [2:0] ext;
    begin
      exit_copy = ext[2] ? ext : run;
    end
  endfunction

  // host writes first, then a standby exit edge overrides run-mode fields
  always @* begin
    mem_ctl_nxt = mem_ctl_r;
    r21_ctl_nxt = r21_ctl_r;
    r15_ctl_nxt = r15_ctl_r;
    if (reg_write_in) begin
      case (reg_addr_in)
        `MEMORY_RAIL_CONTROL_ADDR: begin
          mem_ctl_nxt = reg_wdata_in[5:0];
        end
        `RAIL_2V1_CONTROL_ADDR: begin
          r21_ctl_nxt = reg_wdata_in[5:0];
        end
        `RAIL_1V5_CONTROL_ADDR: begin
          r15_ctl_nxt = reg_wdata_in;
        end
        default: begin
        end
      endcase
    end
    if (exit_rise) begin
      mem_ctl_nxt[2:0] = exit_copy(mem_ctl_nxt[2:0], mem_ctl_nxt[5:3]);
      r21_ctl_nxt[2:0] = exit_copy(r21_ctl_nxt[2:0], r21_ctl_nxt[5:3]);
      r15_ctl_nxt[2:0] = exit_copy(r15_ctl_nxt[2:0], r15_ctl_nxt[5:3]);
    end
  end

  // register state with documented reset values
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_ctl_r <= MEM_CTL_RESET[5:0];
      r21_ctl_r <= R21_CTL_RESET[5:0];
      r15_ctl_r <= `RAIL_1V5_CONTROL_RESET;
    end else begin
      mem_ctl_r <= mem_ctl_nxt;
      r21_ctl_r <= r21_ctl_nxt;
      r15_ctl_r <= r15_ctl_nxt;
    end
  end

  // ****************************************
  // mode decode and discharge
  // ****************************************
  // reserved codes (top bit clear) are held as off
  function [2:0] eff_mode;
    input [2:0] code;
    begin
      eff_mode = code[2] ? code : `MODE_OFF;
    end
  endfunction

  wire [2:0] mem_mode;
  wire [2:0] r21_mode;
  wire [2:0] r15_mode;
  wire [2:0] off_now;
  wire [2:0] off_prev;
  reg [2:0] was_off_r;

  assign mem_mode = eff_mode(mem_ctl_r[2:0]);
  assign r21_mode = eff_mode(r21_ctl_r[2:0]);
  assign r15_mode = eff_mode(r15_ctl_r[2:0]);
  assign off_now = {r15_mode == `MODE_OFF, r21_mode == `MODE_OFF, mem_mode == `MODE_OFF};
  assign off_prev = was_off_r;

  // drive modes; discharge held while off, asserted on every entry into shutdown
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      memory_rail_mode_out <= `MODE_OFF;
      rail_2v1_mode_out <= `MODE_PWM;
      rail_1v5_mode_out <= `MODE_PWM;
      was_off_r <= 3'h1;
      discharge_out <= 3'h1;
      rail_1v5_voltage_select_out <= 1'b0;
    end else begin
      memory_rail_mode_out <= mem_mode;
      rail_2v1_mode_out <= r21_mode;
      rail_1v5_mode_out <= r15_mode;
      was_off_r <= off_now;
      discharge_out <= off_now | (off_now & ~off_prev);
      // 1.6 V when selected, or forced by the gps rail at 1.3 V
      rail_1v5_voltage_select_out <= (r15_ctl_r[7:6] == `VSEL_1V6) | gps_1v3;
    end
  end

  // ****************************************
  // faults and current readings
  // ****************************************
  reg [ADC_WIDTH-1:0] cur_r [0:2];
  integer i;

  // fault flags follow overcurrent; any fault drives the shared irq
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      memory_rail_fault_out <= 1'b0;
      rail_2v1_fault_out <= 1'b0;
      rail_1v5_fault_out <= 1'b0;
      regulator_fault_irq_out <= 1'b0;
    end else begin
      memory_rail_fault_out <= ovc[0];
      rail_2v1_fault_out <= ovc[1];
      rail_1v5_fault_out <= ovc[2];
      regulator_fault_irq_out <= |ovc;
    end
  end

  // store each digitized current by channel
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (i = 0; i < 3; i = i + 1) begin
        cur_r[i] <= {ADC_WIDTH{1'b0}};
      end
    end else if (adc_valid_in && adc_channel_in != 2'h3) begin
      cur_r[adc_channel_in] <= adc_result_in;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // registered read data, zero for unmapped addresses
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        `MEMORY_RAIL_CONTROL_ADDR: reg_rdata_out <= {2'h0, mem_ctl_r};
        `RAIL_2V1_CONTROL_ADDR: reg_rdata_out <= {2'h0, r21_ctl_r};
        `RAIL_1V5_CONTROL_ADDR: reg_rdata_out <= r15_ctl_r;
        `CURRENT_MEMORY_RAIL_ADDR: reg_rdata_out <= cur_r[0][7:0];
        `CURRENT_RAIL_2V1_ADDR: reg_rdata_out <= cur_r[1][7:0];
        `CURRENT_RAIL_1V5_ADDR: reg_rdata_out <= cur_r[2][7:0];
        `FAULT_STATUS_ADDR: reg_rdata_out <= {4'h0, regulator_fault_irq_out, rail_1v5_fault_out,
                                              rail_2v1_fault_out, memory_rail_fault_out};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

endmodule

// ### verification/spi_host_model.sv
// host model of the register port: byte writes and reads with one-cycle strobes
// assumes the block takes a strobe on the rising edge of clk_in
`timescale 1ns/1ps
module spi_host_model (
  input wire clk_in,
  input wire [7:0] rdata_in,
  output reg [7:0] addr_out = 8'h00,
  output reg [7:0] wdata_out = 8'h00,
  output reg write_out = 1'b0,
  output reg read_out = 1'b0
);
  // one write, address scrambled once the strobe drops
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    write_out <= 1'b1;
    @(posedge clk_in);
    write_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  // one read, data taken a cycle after the strobe edge
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    read_out <= 1'b1;
    @(posedge clk_in);
    read_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    #1 d = rdata_in;
  endtask
endmodule

// ### verification/buck_rail_checker.sv
// concurrent checks on the pins of the buck rail bank
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
module buck_rail_checker (
  input wire clk_in,
  input wire resetn_in,
  input wire reg_read_in,
  input wire [7:0] reg_rdata_out,
  input wire [2:0] overcurrent_in,
  input wire gps_comm_rail_1v3_in,
  input wire [2:0] memory_rail_mode_out,
  input wire [2:0] rail_2v1_mode_out,
  input wire [2:0] rail_1v5_mode_out,
  input wire rail_1v5_voltage_select_out,
  input wire [2:0] discharge_out,
  input wire memory_rail_fault_out,
  input wire rail_2v1_fault_out,
  input wire rail_1v5_fault_out,
  input wire regulator_fault_irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_irq_from_faults: assert property (regulator_fault_irq_out ==
    (memory_rail_fault_out | rail_2v1_fault_out | rail_1v5_fault_out)) else $error("irq mismatch");
  a_fault_rises: assert property ($rose(overcurrent_in[0]) |-> ##3 memory_rail_fault_out)
    else $error("memory fault late");
  a_fault_drops: assert property ($fell(overcurrent_in[1]) |-> ##3 !rail_2v1_fault_out)
    else $error("2v1 fault stuck");
  a_discharge_off: assert property (discharge_out == {rail_1v5_mode_out == 3'h4,
    rail_2v1_mode_out == 3'h4, memory_rail_mode_out == 3'h4}) else $error("discharge mismatch");
  a_mode_legal: assert property (memory_rail_mode_out[2] && rail_2v1_mode_out[2]
    && rail_1v5_mode_out[2]) else $error("reserved mode at output");
  a_gps_forces: assert property ($rose(gps_comm_rail_1v3_in) |-> ##3 rail_1v5_voltage_select_out)
    else $error("select not forced");
  a_gps_holds: assert property (gps_comm_rail_1v3_in[*4] |-> rail_1v5_voltage_select_out)
    else $error("select dropped");
  a_rdata_holds: assert property (!reg_read_in |=> $stable(reg_rdata_out))
    else $error("read data moved");
endmodule
bind buck_rail_mode_control buck_rail_checker i_chk (.*);

// ### verification/testbench.sv
// self-checking bench for the buck rail bank, host model on the register port
// assumes the design header is on the include path
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR %0t value %0h expected %0h", $time, (a), (e)); end end
module testbench;
  // ****
  // clock, reset, pins
  // ****
  reg clk_in = 1'b0;
  reg resetn_in = 1'b0;
  reg pin = 1'b0;
  reg [2:0] oc = 3'h0;
  reg gps = 1'b0;
  reg [7:0] adc = 8'h00;
  reg [1:0] ch = 2'h0;
  reg av = 1'b0;
  wire [7:0] a, wd, rdat;
  wire w, r, v15sel, fm, f21, f15, irq;
  wire [2:0] mm, m21, m15, dis;
  logic [7:0] d;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  spi_host_model i_host (.clk_in(clk_in), .rdata_in(rdat), .addr_out(a), .wdata_out(wd), .write_out(w), .read_out(r));
  buck_rail_mode_control i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(a), .reg_wdata_in(wd),
    .reg_write_in(w), .reg_read_in(r), .reg_rdata_out(rdat), .standby_exit_pin_in(pin), .overcurrent_in(oc),
    .gps_comm_rail_1v3_in(gps), .adc_result_in(adc), .adc_channel_in(ch), .adc_valid_in(av),
    .memory_rail_mode_out(mm), .rail_2v1_mode_out(m21), .rail_1v5_mode_out(m15),
    .rail_1v5_voltage_select_out(v15sel), .discharge_out(dis), .memory_rail_fault_out(fm),
    .rail_2v1_fault_out(f21), .rail_1v5_fault_out(f15), .regulator_fault_irq_out(irq));
  // 50 ns clock and a cycle ceiling against hangs
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test;
    end
  end
  task w_(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // ****
  // scenarios
  // ****
  task t_reset;
    i_host.rd(8'h37, d); `CHK(d, 8'h04)
    i_host.rd(8'h38, d); `CHK(d, 8'h07)
    i_host.rd(8'h39, d); `CHK(d, 8'h07)
    `CHK({mm, m21, m15, dis}, {3'h4, 3'h7, 3'h7, 3'h1})
    $display("reset values done");
  endtask
  task t_modes;
    for (int c = 0; c < 8; c++) begin
      i_host.wr(8'h39, {5'h00, c[2:0]});
      w_(3);
      `CHK(m15, (c < 4) ? 3'h4 : c[2:0])
      `CHK(dis[2], c <= 4)
    end
    i_host.wr(8'h37, 8'hff);
    i_host.rd(8'h37, d); `CHK(d, 8'h3f)
    i_host.rd(8'h40, d); `CHK(d, 8'h00)
    $display("mode codes done");
  endtask
  // exit fields: memory copies 6, 2.1 V holds a no-copy code, 1.5 V copies 7
  task t_exit;
    i_host.wr(8'h37, 8'h34);
    i_host.wr(8'h38, 8'h15);
    i_host.wr(8'h39, 8'h3d);
    @(posedge clk_in) pin <= 1'b1;
    w_(6);
    `CHK({mm, m21, m15}, 9'h1af)
    i_host.rd(8'h37, d); `CHK(d, 8'h36)
    i_host.rd(8'h39, d); `CHK(d, 8'h3f)
    @(posedge clk_in) pin <= 1'b0;
    $display("standby exit done");
  endtask
  task t_fault;
    @(posedge clk_in) begin
      oc <= 3'h3;
      adc <= 8'ha5;
      ch <= 2'h1;
      av <= 1'b1;
    end
    @(posedge clk_in) av <= 1'b0;
    w_(4);
    `CHK({fm, f21, f15, irq}, 4'hd)
    i_host.rd(8'h3b, d); `CHK(d, 8'ha5)
    i_host.rd(8'h3d, d); `CHK(d, 8'h0b)
    @(posedge clk_in) oc <= 3'h0;
    w_(5);
    `CHK(irq, 1'b0)
    $display("faults done");
  endtask
  // forcing acts on the output select only, the stored field is left alone
  task t_gps;
    @(posedge clk_in) gps <= 1'b1;
    w_(5);
    `CHK(v15sel, 1'b1)
    i_host.rd(8'h39, d); `CHK(d, 8'h3f)
    @(posedge clk_in) gps <= 1'b0;
    i_host.wr(8'h39, 8'h47);
    w_(5);
    `CHK(v15sel, 1'b1)
    i_host.wr(8'h39, 8'hc7);
    w_(5);
    `CHK(v15sel, 1'b0)
    i_host.wr(8'h39, 8'h07);
    w_(5);
    `CHK(v15sel, 1'b0)
    $display("voltage select done");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_reset;
    t_modes;
    t_exit;
    t_fault;
    t_gps;
    stop_test;
  end
endmodule
